// ===== common/pccs_pkg.sv
// constants and types shared by the polarity chop sequencer
package pccs_pkg;
  localparam int RATE_NUM = 14;
  localparam int RATE_W = 4;
  localparam int CNT_W = 20;
  localparam int DATA_W = 16;
  localparam int SYNC_W = 5;
  // sync vector bit positions
  localparam int SY_TRIG = 0;
  localparam int SY_MCLK = 1;
  localparam int SY_SCLK = 2;
  localparam int SY_CSN = 3;
  localparam int SY_DIN = 4;
  localparam logic [4:0] MCLK_PER_MOD = 5'h10;
  localparam logic [2:0] START_EDGE = 3'h7;
  localparam logic [7:0] START_CMD_DEFAULT = 8'h5a;
  typedef logic [CNT_W-1:0] pccs_cnt_type;
  typedef logic [DATA_W-1:0] pccs_data_type;
  localparam pccs_cnt_type DELAY_DEFAULT = 20'h0_001c;
  // modulator periods per chopped conversion, slowest rate first
  localparam pccs_cnt_type SUB_TABLE [RATE_NUM] = '{
    20'h4_b041, 20'h2_5841, 20'h1_2c41, 20'h0_b441, 20'h0_9641,
    20'h0_3c41, 20'h0_3239, 20'h0_1e41, 20'h0_0f41, 20'h0_07c1,
    20'h0_0401, 20'h0_0328, 20'h0_01a8, 20'h0_00e8};
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT} pccs_state_type;
endpackage

// ===== common/pccs_tmr_if.sv
// carrier between the sequencer and its modulator period timer
`timescale 1ns/10ps
interface pccs_tmr_if;
  import pccs_pkg::*;
  logic start;
  logic mclk_tick;
  pccs_cnt_type target;
  logic done;
  modport ctrl (output start, output mclk_tick, output target, input done);
  modport tmr (input start, input mclk_tick, input target, output done);
endinterface

// ===== rtl/pccs_timer.sv
// counts modulator periods of sixteen master clocks up to a target
`timescale 1ns/10ps
module pccs_timer (
  input wire logic i_core_clk,
  input wire logic i_rst,
  pccs_tmr_if.tmr tif
);
  import pccs_pkg::*;
  logic run_r, run_nxt;
  logic [4:0] sub_r, sub_nxt;
  pccs_cnt_type cnt_r, cnt_nxt;
  pccs_cnt_type tgt_r, tgt_nxt;

  // next state of the period counter
  always_comb begin
    run_nxt = run_r;
    sub_nxt = sub_r;
    cnt_nxt = cnt_r;
    tgt_nxt = tgt_r;
    if (tif.start) begin
      run_nxt = 1'b1;
      sub_nxt = 5'h00;
      cnt_nxt = '0;
      tgt_nxt = tif.target;
    end else if (run_r) begin
      if (cnt_r == tgt_r) begin
        run_nxt = 1'b0;
      end else if (tif.mclk_tick) begin
        if (sub_r == MCLK_PER_MOD - 5'h01) begin
          sub_nxt = 5'h00;
          cnt_nxt = cnt_r + 20'h0_0001;
        end else begin
          sub_nxt = sub_r + 5'h01;
        end
      end
    end
  end

  // register the counter
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      run_r <= 1'b0;
      sub_r <= 5'h00;
      cnt_r <= '0;
      tgt_r <= '0;
    end else begin
      run_r <= run_nxt;
      sub_r <= sub_nxt;
      cnt_r <= cnt_nxt;
      tgt_r <= tgt_nxt;
    end
  end

  // one-cycle pulse when the target is reached; not gated by start, since
  // the sequencer raises start in answer to done and a gate would loop
  assign tif.done = run_r && (cnt_r == tgt_r);
endmodule

// ===== rtl/pccs_sequencer.sv
// polarity chop conversion sequencer for a delta-sigma converter
// Operation
// - chop with input reversal runs only when the chop enable is set at the start
// - start on trigger rising edge or seventh falling clock of start command
// - chop runs single conversions, reversing polarity after each conversion
// - chop output is average of the last two opposite-polarity results
// - continuous chop yields a new average every conversion after the first
// - per-rate conversion period table; later chop results take half as many periods as the first
// - modulator period is sixteen master clocks; settling delay is added
// - settling delay precedes each of the two conversions of a result
// - periods scale with master clock since timing counts master clocks
// - chop output rate drops by filter resettling and settling delay
`timescale 1ns/10ps
module pccs_sequencer #(
  parameter logic [7:0] START_CMD = pccs_pkg::START_CMD_DEFAULT,
  parameter pccs_pkg::pccs_cnt_type SUB_PERIODS [pccs_pkg::RATE_NUM] =
    pccs_pkg::SUB_TABLE
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_mclk,
  input wire logic i_trig,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic i_chop_en,
  input wire logic i_continuous,
  input wire logic [pccs_pkg::RATE_W-1:0] i_rate_sel,
  input wire pccs_pkg::pccs_cnt_type i_settle_delay,
  input wire logic i_stop,
  input wire pccs_pkg::pccs_data_type i_raw_data,
  output logic o_conv_start,
  output logic o_polarity_inv,
  output logic o_busy,
  output pccs_pkg::pccs_data_type o_data,
  output logic o_data_valid
);
  import pccs_pkg::*;

  pccs_tmr_if tif ();

  // reversed result is subtracted so the offset cancels
  function automatic pccs_data_type pccs_avg(input pccs_data_type nrm,
                                             input pccs_data_type rev);
    logic [DATA_W:0] diff;
    diff = {nrm[DATA_W-1], nrm} - {rev[DATA_W-1], rev};
    return diff[DATA_W:1];
  endfunction

  // two-flop synchronisers plus a third stage for edge detection
  logic [SYNC_W-1:0] sy1_r, sy2_r, sy3_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
    end else begin
      sy1_r <= {i_din, i_cs_n, i_sclk, i_mclk, i_trig};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  logic trig_rise, mclk_rise, sclk_fall;
  assign trig_rise = sy2_r[SY_TRIG] && !sy3_r[SY_TRIG];
  assign mclk_rise = sy2_r[SY_MCLK] && !sy3_r[SY_MCLK];
  assign sclk_fall = !sy2_r[SY_SCLK] && sy3_r[SY_SCLK];

  // serial command decoder counting falling clock edges
  logic [2:0] edge_r, edge_nxt;
  logic [5:0] shift_r, shift_nxt;
  logic cmd_start;
  always_comb begin
    edge_nxt = edge_r;
    shift_nxt = shift_r;
    cmd_start = 1'b0;
    if (sy2_r[SY_CSN]) begin
      edge_nxt = 3'h0;
    end else if (sclk_fall) begin
      shift_nxt = {shift_r[4:0], sy2_r[SY_DIN]};
      if (edge_r != START_EDGE) begin
        edge_nxt = edge_r + 3'h1;
      end
      if (edge_r == START_EDGE - 3'h1 &&
          {shift_r, sy2_r[SY_DIN]} == START_CMD[7:1]) begin
        cmd_start = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      edge_r <= 3'h0;
      shift_r <= 6'h00;
    end else begin
      edge_r <= edge_nxt;
      shift_r <= shift_nxt;
    end
  end

  logic go;
  assign go = trig_rise || cmd_start;

  // sequence state
  pccs_state_type state_r, state_nxt;
  logic pol_r, pol_nxt;
  logic have_prev_r, have_prev_nxt;
  logic chop_r, chop_nxt;
  pccs_data_type prev_r, prev_nxt;
  pccs_data_type data_r, data_nxt;
  logic valid_r, valid_nxt;
  logic start_r, start_nxt;
  logic tmr_start;
  pccs_cnt_type tmr_target;
  logic [RATE_W-1:0] rate_idx;

  assign rate_idx = (i_rate_sel < RATE_W'(RATE_NUM)) ? i_rate_sel :
                    RATE_W'(RATE_NUM - 1);

  // next values of the sequence
  always_comb begin
    state_nxt = state_r;
    pol_nxt = pol_r;
    have_prev_nxt = have_prev_r;
    chop_nxt = chop_r;
    prev_nxt = prev_r;
    data_nxt = data_r;
    valid_nxt = 1'b0;
    start_nxt = 1'b0;
    tmr_start = 1'b0;
    tmr_target = i_settle_delay;
    if (go) begin
      // a new start restarts the pair at normal polarity
      state_nxt = ST_SETTLE;
      pol_nxt = 1'b0;
      have_prev_nxt = 1'b0;
      chop_nxt = i_chop_en;
      tmr_start = 1'b1;
      tmr_target = i_settle_delay;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_SETTLE: begin
          if (tif.done) begin
            state_nxt = ST_CONVERT;
            start_nxt = 1'b1;
            tmr_start = 1'b1;
            tmr_target = SUB_PERIODS[rate_idx];
          end
        end
        ST_CONVERT: begin
          if (tif.done) begin
            if (chop_r) begin
              prev_nxt = i_raw_data;
              have_prev_nxt = 1'b1;
              pol_nxt = !pol_r;
              if (have_prev_r) begin
                // pipelined pair yields an average every conversion
                data_nxt = pol_r ? pccs_avg(prev_r, i_raw_data) :
                                   pccs_avg(i_raw_data, prev_r);
                valid_nxt = 1'b1;
              end
            end else begin
              data_nxt = i_raw_data;
              valid_nxt = 1'b1;
            end
            if (i_stop ||
                (!i_continuous && (!chop_r || have_prev_r))) begin
              state_nxt = ST_IDLE;
            end else begin
              state_nxt = ST_SETTLE;
              tmr_start = 1'b1;
              tmr_target = i_settle_delay;
            end
          end
        end
      endcase
      if (i_stop && state_r == ST_SETTLE) begin
        state_nxt = ST_IDLE;
        start_nxt = 1'b0;
        tmr_start = 1'b0;
      end
    end
  end

  // register the sequence
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      pol_r <= 1'b0;
      have_prev_r <= 1'b0;
      chop_r <= 1'b0;
      prev_r <= '0;
      data_r <= '0;
      valid_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pol_r <= pol_nxt;
      have_prev_r <= have_prev_nxt;
      chop_r <= chop_nxt;
      prev_r <= prev_nxt;
      data_r <= data_nxt;
      valid_r <= valid_nxt;
      start_r <= start_nxt;
    end
  end

  // timer hookup
  assign tif.start = tmr_start;
  assign tif.target = tmr_target;
  assign tif.mclk_tick = mclk_rise;

  pccs_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .tif(tif)
  );

  // outputs
  assign o_conv_start = start_r;
  assign o_polarity_inv = pol_r && chop_r;
  assign o_busy = (state_r != ST_IDLE);
  assign o_data = data_r;
  assign o_data_valid = valid_r;
endmodule

// ===== dv/pccs_host.sv
// host model driving the trigger pin and the serial start command
`timescale 1ns/10ps
module pccs_host (
  input wire logic i_core_clk,
  output logic o_trig,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  // idle pins: clock still, not selected
  initial begin
    o_trig = 0;
    o_sclk = 0;
    o_cs_n = 1;
    o_din = 0;
  end
  // wait n falling edges of the core clock
  task automatic fall(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // trigger pulse, held three cycles each way
  task automatic trig();
    o_trig <= 1;
    fall(3);
    o_trig <= 0;
    fall(3);
  endtask
  // msb first, data set on the rising sclk edge, h cycles per half
  task automatic cmd(input logic [7:0] c, input int h);
    o_cs_n <= 0;
    for (int i = 7; i >= 0; i--) begin
      o_sclk <= 1;
      o_din <= c[i];
      fall(h);
      o_sclk <= 0;
      fall(h);
    end
    o_cs_n <= 1;
    o_din <= ~o_din; // released line, stale level not kept
  endtask
endmodule

// ===== dv/pccs_sequencer_asserts.sv
// port assertions of the polarity chop sequencer
`timescale 1ns/10ps
module pccs_sequencer_asserts #(
  parameter pccs_pkg::pccs_cnt_type SUB_PERIODS [pccs_pkg::RATE_NUM] =
    pccs_pkg::SUB_TABLE
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_mclk,
  input wire logic i_trig,
  input wire logic i_chop_en,
  input wire logic [pccs_pkg::RATE_W-1:0] i_rate_sel,
  input wire logic o_conv_start,
  input wire logic o_polarity_inv,
  input wire logic o_busy,
  input wire logic o_data_valid
);
  import pccs_pkg::*;
  int mcnt_r, mcnt_nxt, nst_r, nst_nxt, exp_w;
  logic mclk_r;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // master clock rises per conversion, conversion starts per run
  assign exp_w = 16 * int'(SUB_PERIODS[i_rate_sel > 13 ? 13 : i_rate_sel]);
  always_comb begin
    mcnt_nxt = o_conv_start ? 0 : mcnt_r + int'(i_mclk && !mclk_r);
    nst_nxt = o_busy ? nst_r + int'(o_conv_start) : 0;
  end
  always_ff @(posedge i_core_clk) begin
    mclk_r <= i_mclk;
    mcnt_r <= i_rst ? 0 : mcnt_nxt;
    nst_r <= i_rst ? 0 : nst_nxt;
  end
  sequence s_conv_open;
    o_conv_start ##1 !o_conv_start;
  endsequence
  AST_START_ONE: assert property (o_conv_start |=> !o_conv_start)
    else $error("conv start too long");
  AST_VALID_ONE: assert property (o_data_valid |=> !o_data_valid)
    else $error("valid too long");
  AST_START_BUSY: assert property (o_conv_start |-> o_busy)
    else $error("conv start while idle");
  AST_GO: assert property ($rose(i_trig) |-> ##[1:5] o_busy)
    else $error("trigger not taken");
  AST_POL_HOLD: assert property (s_conv_open |-> $stable(o_polarity_inv)[*6])
    else $error("polarity moved in conversion");
  AST_POL_CHOP: assert property (o_conv_start && !i_chop_en |-> !o_polarity_inv)
    else $error("reversed without chop");
  AST_CONV_LEN: assert property (o_data_valid |-> mcnt_r inside {[exp_w-1:exp_w+1]})
    else $error("conversion length wrong");
  AST_PAIR: assert property (o_data_valid && i_chop_en |-> nst_r >= 2)
    else $error("chop result before pair");
  AST_IDLE_QUIET: assert property (!o_busy && !$past(o_busy) |-> !o_data_valid)
    else $error("result while idle");
endmodule
bind pccs_sequencer pccs_sequencer_asserts #(.SUB_PERIODS(SUB_PERIODS)) u_ast (
  .i_core_clk, .i_rst, .i_mclk, .i_trig, .i_chop_en, .i_rate_sel,
  .o_conv_start, .o_polarity_inv, .o_busy, .o_data_valid);

// ===== dv/pccs_sequencer_tb_top.sv
// self-checking bench of the polarity chop sequencer
`timescale 1ns/10ps
module pccs_sequencer_tb_top;
  import pccs_pkg::*;
  // short conversion periods per rate so every rate index changes timing
  localparam pccs_cnt_type SUBT [RATE_NUM] = '{
    20'h0_0001, 20'h0_0002, 20'h0_0003, 20'h0_0002, 20'h0_0001,
    20'h0_0003, 20'h0_0002, 20'h0_0001, 20'h0_0003, 20'h0_0002,
    20'h0_0001, 20'h0_0003, 20'h0_0002, 20'h0_0001};
  logic clk = 0, rst = 1, mclk = 0, chop, cont, stop, epol;
  logic trig, sclk, csn, din, cs, pol, busy, valid, cpol;
  logic [RATE_W-1:0] rate;
  pccs_cnt_type dly;
  pccs_data_type raw, data, prev, cur, e;
  int seed = 32'h7606_f5cf, err_total = 0, checked = 0, nv = 0, t, x;
  // core clock and a master clock of a quarter its rate
  always #20 clk = ~clk;
  always #80 mclk = ~mclk;
  pccs_host h (.i_core_clk(clk), .o_trig(trig), .o_sclk(sclk),
    .o_cs_n(csn), .o_din(din));
  pccs_sequencer #(.SUB_PERIODS(SUBT)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_mclk(mclk), .i_trig(trig),
    .i_sclk(sclk), .i_cs_n(csn), .i_din(din), .i_chop_en(chop),
    .i_continuous(cont), .i_rate_sel(rate), .i_settle_delay(dly),
    .i_stop(stop), .i_raw_data(raw), .o_conv_start(cs),
    .o_polarity_inv(pol), .o_busy(busy), .o_data(data),
    .o_data_valid(valid));
  // half of normal minus reversed
  function automatic pccs_data_type avg(input pccs_data_type n, r);
    logic signed [16:0] d;
    d = $signed({n[15], n}) - $signed({r[15], r});
    return d[16:1];
  endfunction
  // conversion periods the bench expects for a rate index
  function automatic int subp(input logic [RATE_W-1:0] r);
    return int'(SUBT[(r < RATE_NUM) ? r : RATE_W'(RATE_NUM - 1)]);
  endfunction
  task automatic chk(input string n, input logic [31:0] x, g);
    checked++;
    if (x !== g) begin
      err_total++;
      $display("mismatch %s exp %0h got %0h", n, x, g);
    end
  endtask
  // fresh raw word per conversion; every result word checked
  // expected polarity starts normal each sequence and flips per chop conversion
  always @(negedge clk) begin
    if (!busy) epol = 1'b0;
    if (cs) begin
      chk("pol", epol && chop, pol);
      prev = cur;
      cur = pccs_data_type'($random(seed));
      cpol = epol;
      epol = chop && !epol;
      raw <= cur;
    end
    if (valid) begin
      nv++;
      e = !chop ? cur : cpol ? avg(prev, cur) : avg(cur, prev);
      chk("data", e, data);
    end
  end
  // one sequence: start, time the results, stop if continuous, back to idle
  task automatic run(input bit c, k, sp);
    chop <= c;
    cont <= k;
    rate <= $random(seed);
    dly <= pccs_cnt_type'(1 + {$random(seed)} % 3);
    nv = 0;
    t = 0;
    if (sp) h.cmd(START_CMD_DEFAULT, 2 + {$random(seed)} % 2 * 2);
    else h.trig();
    while (nv == 0 && t < 5000) begin h.fall(1); t++; end
    x = (c ? 2 : 1) * (dly + subp(rate));
    chk("first", x, (t + 40) / 64);
    t = 0;
    if (k) begin
      while (nv == 1 && t < 5000) begin h.fall(1); t++; end
      x = dly + subp(rate);
      chk("next", x, (t + 32) / 64);
      stop <= 1;
    end
    while (busy && t < 9000) begin h.fall(1); t++; end
    stop <= 0;
    h.fall(9);
    chk("busy", 0, busy);
    if (!k) chk("count", 1, nv);
    $display("test done chop %0d cont %0d", c, k);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    chop = 0;
    cont = 0;
    stop = 0;
    rate = '0;
    dly = DELAY_DEFAULT;
    h.fall(5);
    rst <= 0;
    h.fall(2);
    run(0, 0, 0);
    run(1, 0, 1);
    run(1, 1, 0);
    run(0, 1, 1);
    h.cmd(~START_CMD_DEFAULT, 2);
    h.fall(20);
    chk("wrong cmd", 0, busy);
    $display("test done wrong command");
    for (int i = 0; i < 4; i++) run($random(seed), $random(seed), $random(seed));
    conclude();
  end
  // watchdog past the longest expected run
  initial begin
    #2400000;
    err_total++;
    conclude();
  end
endmodule
